// ==== include/dibc_if.sv ====
`timescale 1ns/100ps
interface dibc_if;
    logic       data_command_select;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [7:0] data;
    modport host (output data_command_select, output read_strobe_n, output write_strobe_n, output data);
    modport device (input data_command_select, input read_strobe_n, input write_strobe_n, input data);
endinterface : dibc_if

// ==== include/dibc_pkg.sv ====
package dibc_pkg;
    // command codes
    localparam logic [7:0] CMD_NORMAL_DISPLAY = 8'h13;
    localparam logic [7:0] CMD_PARTIAL        = 8'h12;
    localparam logic [7:0] CMD_INV_DISABLE    = 8'h20;
    localparam logic [7:0] CMD_INV_ENABLE     = 8'h21;
    localparam logic [7:0] CMD_FORCE_BLACK    = 8'h22;
    localparam logic [7:0] CMD_FORCE_WHITE    = 8'h23;
    // widths
    localparam int PIXEL_W = 18;
    // wishbone register offsets (byte addresses)
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    // status field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_INV   = 1;
    localparam int ST_BLACK = 2;
    localparam int ST_WHITE = 3;
    localparam int ST_PTL   = 4;
    // strobe low phase and recovery, in clock cycles
    localparam int STROBE_LOW_CYC  = 2;
    localparam int STROBE_HIGH_CYC = 2;
    localparam logic [2:0] STROBE_CNT_RST = 3'h0;
    typedef enum logic [1:0] {DIBC_IDLE, DIBC_LOW, DIBC_HIGH} dibc_state_t;
endpackage : dibc_pkg

// ==== rtl/dibc_device.sv ====
`timescale 1ns/100ps
// How it works
// - code 20h, no parameters, leaves inversion
// - inversion off passes memory data unaltered
// - repeated disable changes nothing
// - code 21h, no parameters, enters inversion
// - inversion complements every pixel bit
// - inversion cleared only by 20h or reset
// - repeated enable changes nothing
// - code 22h, no parameters, forces black
// - black applies when awake, any display state
// - commands never touch frame memory
// - 20h/21h touch only inversion; 12h, 13h, 22h, 23h also clear black/white
// - white, normal or partial exits black
// - normal/partial exit shows memory again
// - force black ignored while inverted
// - code 23h forces white when awake
// - code 13h ends partial mode
module dibc_device (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    dibc_if.device                             bus,
    input  wire logic                          sleep_i,
    input  wire logic [dibc_pkg::PIXEL_W-1:0]  mem_pixel_i,
    output logic      [dibc_pkg::PIXEL_W-1:0]  panel_pixel_o,
    output logic                               inv_o,
    output logic                               black_o,
    output logic                               white_o,
    output logic                               partial_o
);
    // pin synchroniser stages; first stage feeds only the second
    logic                         dcs_s1_reg;
    logic                         dcs_s2_reg;
    logic                         rd_s1_reg;
    logic                         rd_s2_reg;
    logic                         wr_s1_reg;
    logic                         wr_s2_reg;
    logic                         wr_s3_reg;
    logic [7:0]                   dat_s1_reg;
    logic [7:0]                   dat_s2_reg;
    // mode flags and their next values
    logic                         inv_reg;
    logic                         inv_next;
    logic                         black_reg;
    logic                         black_next;
    logic                         white_reg;
    logic                         white_next;
    logic                         ptl_reg;
    logic                         ptl_next;
    // registered panel drive word
    logic [dibc_pkg::PIXEL_W-1:0] pix_reg;

    // true when a taken command carries the given code
    function automatic logic code_is(
        input logic       take,
        input logic [7:0] seen,
        input logic [7:0] code
    );
        code_is = take & (seen == code);
    endfunction : code_is

    // pixel source: overrides win over the memory word
    function automatic logic [dibc_pkg::PIXEL_W-1:0] drive_word(
        input logic                         blank,
        input logic                         flood,
        input logic                         invert,
        input logic [dibc_pkg::PIXEL_W-1:0] stored
    );
        if (blank) begin
            drive_word = '0;
        end else if (flood) begin
            drive_word = '1;
        end else if (invert) begin
            drive_word = ~stored;
        end else begin
            drive_word = stored;
        end
    endfunction : drive_word

    // select pin synchroniser
    always_ff @(posedge clk_i) begin
        dcs_s1_reg <= bus.data_command_select;
        dcs_s2_reg <= dcs_s1_reg;
    end

    // read strobe synchroniser
    always_ff @(posedge clk_i) begin
        rd_s1_reg <= bus.read_strobe_n;
        rd_s2_reg <= rd_s1_reg;
    end

    // write strobe synchroniser plus edge history stage
    always_ff @(posedge clk_i) begin
        wr_s1_reg <= bus.write_strobe_n;
        wr_s2_reg <= wr_s1_reg;
        wr_s3_reg <= wr_s2_reg;
    end

    // command byte synchroniser; stable long before the strobe rises
    always_ff @(posedge clk_i) begin
        dat_s1_reg <= bus.data;
        dat_s2_reg <= dat_s1_reg;
    end

    // command strobe on rising write edge, select low, read idle
    wire cmd_take = wr_s2_reg & ~wr_s3_reg & ~dcs_s2_reg & rd_s2_reg;
    wire is_off   = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_INV_DISABLE);
    wire is_on    = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_INV_ENABLE);
    wire is_black = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_FORCE_BLACK) & ~inv_reg;
    wire is_white = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_FORCE_WHITE);
    wire is_norm  = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_NORMAL_DISPLAY);
    wire is_ptl   = code_is(cmd_take, dat_s2_reg, dibc_pkg::CMD_PARTIAL);
    wire awake    = ~sleep_i;

    // inversion flag: only its own two codes move it
    always_comb begin
        inv_next = inv_reg;
        if (is_on) begin
            inv_next = 1'b1;
        end else if (is_off) begin
            inv_next = 1'b0;
        end
    end

    // black override: set by its code, left by white, normal, partial
    always_comb begin
        black_next = black_reg;
        if (is_black) begin
            black_next = 1'b1;
        end else if (is_white | is_norm | is_ptl) begin
            black_next = 1'b0;
        end
    end

    // white override: set by its code, left by black, normal, partial
    always_comb begin
        white_next = white_reg;
        if (is_white) begin
            white_next = 1'b1;
        end else if (is_black | is_norm | is_ptl) begin
            white_next = 1'b0;
        end
    end

    // partial flag: set by its code, cleared by normal
    always_comb begin
        ptl_next = ptl_reg;
        if (is_ptl) begin
            ptl_next = 1'b1;
        end else if (is_norm) begin
            ptl_next = 1'b0;
        end
    end

    // inversion flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inv_reg <= 1'b0;
        end else begin
            inv_reg <= inv_next;
        end
    end

    // black flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            black_reg <= 1'b0;
        end else begin
            black_reg <= black_next;
        end
    end

    // white flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            white_reg <= 1'b0;
        end else begin
            white_reg <= white_next;
        end
    end

    // partial flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptl_reg <= 1'b0;
        end else begin
            ptl_reg <= ptl_next;
        end
    end

    // memory read path only; no write path exists, overrides need awake
    wire [dibc_pkg::PIXEL_W-1:0] pix_next = drive_word(black_reg & awake,
                                                       white_reg & awake,
                                                       inv_reg,
                                                       mem_pixel_i);

    // panel word register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pix_reg <= '0;
        end else begin
            pix_reg <= pix_next;
        end
    end

    assign panel_pixel_o = pix_reg;
    assign inv_o         = inv_reg;
    assign black_o       = black_reg;
    assign white_o       = white_reg;
    assign partial_o     = ptl_reg;
endmodule : dibc_device

// ==== rtl/dibc_host.sv ====
`timescale 1ns/100ps
module dibc_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    dibc_if.host             bus,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    dibc_pkg::dibc_state_t state_reg, state_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [7:0]  code_reg;
    logic        wr_n_reg, ack_reg;
    logic [31:0] rdat_reg;

    // bus decode
    wire req       = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire sel_cmd   = wb_adr_i == dibc_pkg::REG_CMD;
    wire sel_stat  = wb_adr_i == dibc_pkg::REG_STATUS;
    wire busy      = state_reg != dibc_pkg::DIBC_IDLE;
    wire launch    = req & wb_we_i & sel_cmd & wb_sel_i[0] & ~busy;
    wire [31:0] status_word = {31'h0, busy};

    // strobe sequencer: low phase then recovery
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            dibc_pkg::DIBC_IDLE: begin
                if (launch) begin
                    state_next = dibc_pkg::DIBC_LOW;
                    cnt_next   = dibc_pkg::STROBE_CNT_RST;
                end
            end
            dibc_pkg::DIBC_LOW: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == 3'(dibc_pkg::STROBE_LOW_CYC - 1)) begin
                    state_next = dibc_pkg::DIBC_HIGH;
                    cnt_next   = dibc_pkg::STROBE_CNT_RST;
                end
            end
            dibc_pkg::DIBC_HIGH: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == 3'(dibc_pkg::STROBE_HIGH_CYC - 1)) begin
                    state_next = dibc_pkg::DIBC_IDLE;
                end
            end
            default: state_next = dibc_pkg::DIBC_IDLE;
        endcase
    end

    // command written with select low, read strobe high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= dibc_pkg::DIBC_IDLE;
            cnt_reg   <= dibc_pkg::STROBE_CNT_RST;
            code_reg  <= 8'h00;
            wr_n_reg  <= 1'b1;
            ack_reg   <= 1'b0;
            rdat_reg  <= 32'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if (launch) begin
                code_reg <= wb_dat_i[7:0];
            end
            wr_n_reg  <= (state_next != dibc_pkg::DIBC_LOW);
            ack_reg   <= req;
            rdat_reg  <= sel_stat ? status_word : 32'h0;
        end
    end

    assign bus.data_command_select = 1'b0;
    assign bus.read_strobe_n       = 1'b1;
    assign bus.write_strobe_n      = wr_n_reg;
    assign bus.data                = code_reg;
    assign wb_ack_o                = ack_reg;
    assign wb_dat_o                = rdat_reg;
endmodule : dibc_host

// ==== tb/dibc_checker.sv ====
`timescale 1ns/100ps
module dibc_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       data_command_select,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic [7:0] data
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // command phase pins and strobe timing
    sel_low_a: assert property (data_command_select == 1'b0) else $error("select not low");
    rd_high_a: assert property (read_strobe_n == 1'b1) else $error("read strobe not high");
    low_len_a: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
        else $error("strobe low phase wrong");
    rec_len_a: assert property ($rose(write_strobe_n) |-> write_strobe_n [*2]) else $error("short recovery");
    data_hold_a: assert property (!write_strobe_n && !$fell(write_strobe_n) |-> $stable(data))
        else $error("code moved while strobe low");
    rise_hold_a: assert property ($rose(write_strobe_n) |-> $stable(data)) else $error("code moved at rise");
    code_ok_a: assert property ($fell(write_strobe_n) |-> data inside {8'h12, 8'h13, 8'h20, 8'h21, 8'h22, 8'h23})
        else $error("unknown code sent");
    rst_idle_a: assert property ($fell(rst_i) |-> write_strobe_n && data == 8'h00) else $error("pins busy after reset");
    // main traffic seen
    cover property ($fell(write_strobe_n) && data == 8'h21);
    cover property ($fell(write_strobe_n) && data == 8'h20);
    cover property ($fell(write_strobe_n) && data == 8'h22);
endmodule : dibc_checker

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sleep_i = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [17:0] mem = 18'h2d3c5, pix;
    logic        inv, blk, wht, ptl;
    int          err_count = 0, checks_done = 0, i;
    // rows: code, then expected inv, black, white, partial
    logic [11:0] rows [11] = '{12'h218, 12'h218, 12'h228, 12'h200, 12'h200, 12'h224,
                               12'h232, 12'h224, 12'h121, 12'h225, 12'h130};
    dibc_if bus ();
    dibc_host u_dibc_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    dibc_device u_dibc_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .sleep_i(sleep_i), .mem_pixel_i(mem),
        .panel_pixel_o(pix), .inv_o(inv), .black_o(blk), .white_o(wht), .partial_o(ptl));
    dibc_checker u_dibc_checker (.clk_i(clk_i), .rst_i(rst_i), .data_command_select(bus.data_command_select),
        .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n), .data(bus.data));
    // clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // one classic wishbone cycle, held until ack
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        while (ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 40) begin
                err_count++;
                end_of_test();
            end
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    // send a code, poll busy, let the link settle
    task cmd(input logic [7:0] c);
        int n;
        n = 0;
        wb(1'b1, 4'h0, {24'h0, c});
        do begin
            wb(1'b0, 4'h4, 32'h0);
            n++;
            if (n > 20) begin
                err_count++;
                end_of_test();
            end
        end while (q[0] !== 1'b0);
        repeat (6) @(posedge clk_i);
    endtask : cmd
    // mode flags and panel pixel against expectation
    task flags(input logic [3:0] f);
        logic [17:0] e;
        e = f[2] ? 18'h0 : f[1] ? 18'h3ffff : f[3] ? ~mem : mem;
        chk({inv, blk, wht, ptl}, f);
        chk(pix, e);
    endtask : flags
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        flags(4'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        for (i = 0; i < 11; i++) begin
            cmd(rows[i][11:4]);
            flags(rows[i][3:0]);
        end
        // black override only while awake
        cmd(8'h22);
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(pix, mem);
        chk(blk, 1'b1);
        sleep_i <= 1'b0;
        // reset in mid-run clears inversion
        cmd(8'h13);
        cmd(8'h21);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        flags(4'h0);
        end_of_test();
    end
endmodule : tb
